// ===== hdl/uart_shadow_pkg.sv
// Constants for the UART shadow data port: register map, fields, timing.
// Assumes a 32-bit classic Wishbone slave clocked at 25 MHz.
// Behaviour
// - Shadow read returns received byte, bits 7:0.
// - FIFO off: new character overwrites, flags overrun.
// - FIFO on: shadow read returns receive FIFO head.
// - Full receive FIFO: keep contents, drop, overrun.
// - Sixteen aliased word locations share one data path.
// - Shadow write queues byte for serial or infrared.
// - FIFO off: one write clears holding-empty flag.
// - FIFO off: further writes overwrite pending byte.
// - FIFO on: accept writes up to FIFO depth.
// - Write to full transmit FIFO is discarded.
package uart_shadow_pkg;
   // Documented address of alias five and the alias layout.
   localparam logic [31:0] SHADOW_RX_TX_DATA_5_ADDR = 32'h5000_1044;
   localparam logic [31:0] ALIAS_STRIDE             = 32'h0000_0004;
   localparam logic [31:0] ALIAS_FIVE               = 32'h0000_0005;
   localparam logic [29:0] SHADOW_ALIASES           = 30'h0000_0010;
   localparam logic [31:0] SHADOW_BASE_ADDR         =
      SHADOW_RX_TX_DATA_5_ADDR - ALIAS_FIVE * ALIAS_STRIDE;
   // Control and status registers of this block.
   localparam logic [31:0] CTRL_ADDR        = 32'h5000_1080;
   localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1084;
   localparam logic [31:0] IRQ_STATUS_ADDR  = 32'h5000_1088;
   localparam logic [31:0] IRQ_ENABLE_ADDR  = 32'h5000_108C;
   localparam logic [31:0] IRQ_CLEAR_ADDR   = 32'h5000_1090;
   // Control fields and reset value.
   localparam int          CTRL_FIFO_EN_BIT = 0;
   localparam int          CTRL_IR_BIT      = 1;
   localparam logic [1:0]  CTRL_RESET       = 2'h0;
   // Line status fields.
   localparam int          LSR_DR_BIT   = 0;
   localparam int          LSR_OE_BIT   = 1;
   localparam int          LSR_FE_BIT   = 3;
   localparam int          LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
   localparam int          LSR_TEMT_BIT = 6;
   // Interrupt status, enable and clear layout.
   localparam int          IRQ_W        = 4;
   localparam int          IRQ_RX_BIT   = 0;
   localparam int          IRQ_OVR_BIT  = 1;
   localparam int          IRQ_TX_HOLDING_EMPTY_FLAG_BIT = 2;
   localparam int          IRQ_FE_BIT   = 3;
   localparam logic [3:0]  IRQ_RESET    = 4'h0;
   // Serial timing: 16 ticks per bit, mid-bit start check, 3/16 IR pulse.
   localparam int          CLK_HZ       = 25_000_000;
   localparam int          OVERSAMPLE   = 16;
   localparam logic [3:0]  TICK_LAST    = 4'hF;
   localparam logic [3:0]  TICK_MID     = 4'h7;
   localparam logic [3:0]  IR_PULSE     = 4'h3;
   localparam logic [4:0]  IR_STRETCH   = 5'h10;
   localparam logic [2:0]  BIT_LAST     = 3'h7;
   localparam int          FIFO_DEPTH_DEFAULT = 16;
endpackage : uart_shadow_pkg

// ===== hdl/uart_shadow_rx_tx_data_port.sv
// UART shadow data port: Wishbone slave, receive and transmit paths.
// Assumes one 25 MHz clock, synchronous reset and asynchronous line pins.
//
// The Wishbone interface to the registers was left to the implementer.

// Byte queue that also serves as a single holding register.
module uart_shadow_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // Clock and control.
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   input  wire logic                         flush_i,
   input  wire logic                         single_i,
   // Fill and drain sides.
   input  wire logic                         push_i,
   input  wire logic [W-1:0]                 din_i,
   input  wire logic                         pop_i,
   output logic      [W-1:0]                 dout_o,
   output logic      [$clog2(DEPTH):0]       count_o,
   output logic                              full_o,
   output logic                              lost_o
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("FIFO depth must be a power of two, at least two.");
   end
   logic [W-1:0]  mem [DEPTH];  // Storage, indexed by pointer.
   logic [AW-1:0] rd_ptr;       // Head index.
   logic [AW-1:0] wr_ptr;       // Tail index.
   logic          do_pop;       // Pop of a present entry.
   logic          do_push;      // Push into a free slot.
   logic          overwrite;    // Single mode replaces the held entry.

   // Full means one entry in single mode, DEPTH entries otherwise.
   always_comb
   begin
      full_o    = single_i ? (count_o != '0) : (count_o == (AW+1)'(DEPTH));
      do_pop    = pop_i && (count_o != '0);
      do_push   = push_i && (!full_o || do_pop);
      overwrite = push_i && single_i && full_o && !do_pop;
      lost_o    = push_i && full_o && !do_pop;
      dout_o    = mem[rd_ptr];
   end

   // Pointers and count; a full queue drops the push unchanged.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || (ce_i && flush_i))
      begin
         rd_ptr  <= '0;
         wr_ptr  <= '0;
         count_o <= '0;
      end
      else if (ce_i)
      begin
         if (do_push)
         begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count_o <= count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

   // Data storage; reset clears it so an empty path reads zero, not unknown.
   // The overwrite replaces the unread entry.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem[i] <= '0;
         end
      end
      else if (ce_i && do_push)
      begin
         mem[wr_ptr] <= din_i;
      end
      else if (ce_i && overwrite)
      begin
         mem[rd_ptr] <= din_i;
      end
   end
endmodule // uart_shadow_fifo

module uart_shadow_rx_tx_data_port #(
   parameter int BAUD       = 115200,
   parameter int FIFO_DEPTH = uart_shadow_pkg::FIFO_DEPTH_DEFAULT
) (
   // Clock, reset and clock enable.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // Wishbone classic slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Serial and infrared line pins.
   input  wire logic        sin_i,
   input  wire logic        sir_in_i,
   output logic             sout_o,
   output logic             sir_out_n_o,
   // Interrupt.
   output logic             irq_o
);
   localparam int TICK_DIV = uart_shadow_pkg::CLK_HZ / (BAUD * uart_shadow_pkg::OVERSAMPLE);
   localparam int DW = $clog2(TICK_DIV + 1);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   if (TICK_DIV < 1)
   begin : g_bad_baud
      $error("Baud rate too high for the clock.");
   end

   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_START = 4'b0010,
      S_DATA  = 4'b0100,
      S_STOP  = 4'b1000
   } line_state_e;

   logic              req;          // New bus request this cycle.
   logic [29:0]       shadow_idx;   // Word index from alias zero.
   logic              shadow_hit;   // Address hits one of the aliases.
   logic              rd_pop;       // Shadow read takes the receive head.
   logic              wr_shadow;    // Shadow write loads the transmit path.
   logic              ctrl_wr;      // Control register write.
   logic              lsr_rd;       // Line status read.
   logic [31:0]       next_rdata;   // Read data for the current address.
   logic              fifo_en;      // FIFOs enabled.
   logic              ir_mode;      // Infrared line selected.
   logic              fifo_flush;   // FIFO mode change empties both queues.
   logic              oe;           // Sticky overrun error.
   logic              fe;           // Sticky framing error.
   logic [3:0]        irq_status;   // Sticky events.
   logic [3:0]        irq_en;       // Interrupt enables.
   logic [3:0]        irq_set;      // Events this cycle.
   logic [3:0]        irq_clr;      // Clear-register write bits.
   logic              tx_holding_empty_flag_q;       // Previous holding-empty flag.
   logic [DW-1:0]     div_cnt;      // Tick divider.
   logic              tick;         // Sixteen-times bit-rate tick.
   logic              sin_m, sin_s; // Serial input synchroniser.
   logic              sir_m, sir_s; // Infrared input synchroniser.
   logic [4:0]        stretch;      // Infrared pulse stretched to one bit.
   logic              rxd;          // Receive line level, normal polarity.
   line_state_e       rx_state;
   logic [3:0]        rx_cnt;
   logic [2:0]        rx_bits;
   logic [7:0]        rx_shift;
   logic              rx_push;      // Good stop bit: character ready.
   logic              fe_evt;       // Bad stop bit.
   logic [7:0]        rx_dout;
   logic [CW-1:0]     rx_count;
   logic              rx_full;
   logic              rx_lost;      // Arrival into a full path.
   line_state_e       tx_state;
   logic [3:0]        tx_cnt;
   logic [2:0]        tx_bits;
   logic [7:0]        tx_shift;
   logic              tx_line;      // Transmit bit level.
   logic              tx_load;      // Transmitter takes the head byte.
   logic [7:0]        tx_dout;
   logic [CW-1:0]     tx_count;
   logic              tx_full;
   logic              dr;           // Data ready.
   logic              tx_holding_empty_flag;         // Transmit holding empty.

   // Bus decode: all sixteen aliases reach the same data path.
   always_comb
   begin
      req        = cyc_i && stb_i && !ack_o;
      shadow_idx = adr_i[31:2] - uart_shadow_pkg::SHADOW_BASE_ADDR[31:2];
      shadow_hit = shadow_idx < uart_shadow_pkg::SHADOW_ALIASES;
      rd_pop     = req && !we_i && shadow_hit;
      wr_shadow  = req && we_i && shadow_hit && sel_i[0];
      ctrl_wr    = req && we_i && sel_i[0]
                   && adr_i[31:2] == uart_shadow_pkg::CTRL_ADDR[31:2];
      lsr_rd     = req && !we_i && adr_i[31:2] == uart_shadow_pkg::LINE_STATUS_ADDR[31:2];
      irq_clr    = (req && we_i && sel_i[0]
                   && adr_i[31:2] == uart_shadow_pkg::IRQ_CLEAR_ADDR[31:2])
                   ? dat_i[3:0] : '0;
      fifo_flush = ctrl_wr && (dat_i[uart_shadow_pkg::CTRL_FIFO_EN_BIT] != fifo_en);
      dr         = rx_count != '0;
      tx_holding_empty_flag       = tx_count == '0;
   end

   // Read multiplexer; unmapped words read zero.
   always_comb
   begin
      next_rdata = '0;
      if (shadow_hit)
      begin
         next_rdata[7:0] = rx_dout;
      end
      else if (adr_i[31:2] == uart_shadow_pkg::CTRL_ADDR[31:2])
      begin
         next_rdata[uart_shadow_pkg::CTRL_FIFO_EN_BIT] = fifo_en;
         next_rdata[uart_shadow_pkg::CTRL_IR_BIT]      = ir_mode;
      end
      else if (adr_i[31:2] == uart_shadow_pkg::LINE_STATUS_ADDR[31:2])
      begin
         next_rdata[uart_shadow_pkg::LSR_DR_BIT]   = dr;
         next_rdata[uart_shadow_pkg::LSR_OE_BIT]   = oe;
         next_rdata[uart_shadow_pkg::LSR_FE_BIT]   = fe;
         next_rdata[uart_shadow_pkg::LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
         next_rdata[uart_shadow_pkg::LSR_TEMT_BIT] = tx_holding_empty_flag && tx_state == S_IDLE;
      end
      else if (adr_i[31:2] == uart_shadow_pkg::IRQ_STATUS_ADDR[31:2])
      begin
         next_rdata[3:0] = irq_status;
      end
      else if (adr_i[31:2] == uart_shadow_pkg::IRQ_ENABLE_ADDR[31:2])
      begin
         next_rdata[3:0] = irq_en;
      end
   end

   // Acknowledge every request after one cycle, mapped or not.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end
      else if (ce_i)
      begin
         ack_o <= req;
         if (req)
         begin
            dat_o <= we_i ? '0 : next_rdata;
         end
      end
   end

   // Control and enable registers.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         {ir_mode, fifo_en} <= uart_shadow_pkg::CTRL_RESET;
         irq_en             <= uart_shadow_pkg::IRQ_RESET;
      end
      else if (ce_i)
      begin
         if (ctrl_wr)
         begin
            fifo_en <= dat_i[uart_shadow_pkg::CTRL_FIFO_EN_BIT];
            ir_mode <= dat_i[uart_shadow_pkg::CTRL_IR_BIT];
         end
         if (req && we_i && sel_i[0]
             && adr_i[31:2] == uart_shadow_pkg::IRQ_ENABLE_ADDR[31:2])
         begin
            irq_en <= dat_i[3:0];
         end
      end
   end

   // Sticky errors and events; a set in the clear cycle wins.
   always_comb
   begin
      irq_set = '0;
      irq_set[uart_shadow_pkg::IRQ_RX_BIT]   = rx_push;
      irq_set[uart_shadow_pkg::IRQ_OVR_BIT]  = rx_lost;
      irq_set[uart_shadow_pkg::IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag && !tx_holding_empty_flag_q;
      irq_set[uart_shadow_pkg::IRQ_FE_BIT]   = fe_evt;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         oe         <= 1'b0;
         fe         <= 1'b0;
         tx_holding_empty_flag_q     <= 1'b1;
         irq_status <= uart_shadow_pkg::IRQ_RESET;
         irq_o      <= 1'b0;
      end
      else if (ce_i)
      begin
         oe         <= rx_lost || (oe && !lsr_rd);
         fe         <= fe_evt || (fe && !lsr_rd);
         tx_holding_empty_flag_q     <= tx_holding_empty_flag;
         irq_status <= irq_set | (irq_status & ~irq_clr);
         irq_o      <= |(irq_status & irq_en);
      end
   end

   // Tick divider and input synchronisers.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt <= '0;
         // Synchronisers start at the idle line levels, so no false start follows reset.
         {sin_m, sin_s, sir_m, sir_s} <= 4'hC;
         stretch <= '0;
      end
      else if (ce_i)
      begin
         div_cnt <= tick ? DW'(TICK_DIV - 1) : div_cnt - 1'b1;
         sin_m   <= sin_i;
         sin_s   <= sin_m;
         sir_m   <= sir_in_i;
         sir_s   <= sir_m;
         // An infrared pulse marks a zero bit lasting one bit time.
         if (sir_s)
         begin
            stretch <= uart_shadow_pkg::IR_STRETCH;
         end
         else if (tick && stretch != '0)
         begin
            stretch <= stretch - 1'b1;
         end
      end
   end

   always_comb
   begin
      tick    = div_cnt == '0;
      rxd     = ir_mode ? (stretch == '0) : sin_s;
      rx_push = rx_state == S_STOP && tick && rx_cnt == uart_shadow_pkg::TICK_LAST && rxd;
      fe_evt  = rx_state == S_STOP && tick && rx_cnt == uart_shadow_pkg::TICK_LAST && !rxd;
      tx_load = tx_state == S_IDLE && tick && tx_count != '0;
   end

   // Receiver: start check at mid-bit, then one sample per bit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_state <= S_IDLE;
         rx_cnt   <= '0;
         rx_bits  <= '0;
         rx_shift <= '0;
      end
      else if (ce_i)
      begin
         if (tick)
         begin
            rx_cnt <= rx_cnt + 1'b1;
         end
         case (rx_state)
            S_IDLE:
            begin
               rx_cnt <= '0;
               if (!rxd)
               begin
                  rx_state <= S_START;
               end
            end
            S_START:
            begin
               if (tick && rx_cnt == uart_shadow_pkg::TICK_MID)
               begin
                  rx_cnt   <= '0;
                  rx_bits  <= '0;
                  rx_state <= rxd ? S_IDLE : S_DATA;
               end
            end
            S_DATA:
            begin
               if (tick && rx_cnt == uart_shadow_pkg::TICK_LAST)
               begin
                  rx_shift <= {rxd, rx_shift[7:1]};
                  rx_bits  <= rx_bits + 1'b1;
                  if (rx_bits == uart_shadow_pkg::BIT_LAST)
                  begin
                     rx_state <= S_STOP;
                  end
               end
            end
            S_STOP:
            begin
               if (tick && rx_cnt == uart_shadow_pkg::TICK_LAST)
               begin
                  rx_state <= S_IDLE;
               end
            end
            default:
            begin
               rx_state <= S_IDLE;
            end
         endcase
      end
   end

   // Receive path; single mode overwrites the unread byte.
   uart_shadow_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .flush_i  (fifo_flush),
      .single_i (!fifo_en),
      .push_i   (rx_push),
      .din_i    (rx_shift),
      .pop_i    (rd_pop),
      .dout_o   (rx_dout),
      .count_o  (rx_count),
      .full_o   (rx_full),
      .lost_o   (rx_lost)
   );

   // Transmit path; full FIFO drops, single mode overwrites.
   uart_shadow_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .flush_i  (fifo_flush),
      .single_i (!fifo_en),
      .push_i   (wr_shadow),
      .din_i    (dat_i[7:0]),
      .pop_i    (tx_load),
      .dout_o   (tx_dout),
      .count_o  (tx_count),
      .full_o   (tx_full),
      .lost_o   ()
   );

   // Transmitter: start bit, eight data bits LSB first, stop bit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_state <= S_IDLE;
         tx_cnt   <= '0;
         tx_bits  <= '0;
         tx_shift <= '0;
         tx_line  <= 1'b1;
      end
      else if (ce_i && tick)
      begin
         tx_cnt <= tx_cnt + 1'b1;
         case (tx_state)
            S_IDLE:
            begin
               tx_cnt  <= '0;
               tx_line <= 1'b1;
               if (tx_load)
               begin
                  tx_shift <= tx_dout;
                  tx_line  <= 1'b0;
                  tx_state <= S_START;
               end
            end
            S_START:
            begin
               if (tx_cnt == uart_shadow_pkg::TICK_LAST)
               begin
                  tx_line  <= tx_shift[0];
                  tx_bits  <= '0;
                  tx_state <= S_DATA;
               end
            end
            S_DATA:
            begin
               if (tx_cnt == uart_shadow_pkg::TICK_LAST)
               begin
                  tx_shift <= {1'b1, tx_shift[7:1]};
                  tx_line  <= tx_bits == uart_shadow_pkg::BIT_LAST ? 1'b1 : tx_shift[1];
                  tx_bits  <= tx_bits + 1'b1;
                  if (tx_bits == uart_shadow_pkg::BIT_LAST)
                  begin
                     tx_state <= S_STOP;
                  end
               end
            end
            S_STOP:
            begin
               if (tx_cnt == uart_shadow_pkg::TICK_LAST)
               begin
                  tx_state <= S_IDLE;
               end
            end
            default:
            begin
               tx_state <= S_IDLE;
            end
         endcase
      end
   end

   // Pins: normal line, or a 3/16-bit active-low pulse per zero bit.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sout_o      <= 1'b1;
         sir_out_n_o <= 1'b1;
      end
      else if (ce_i)
      begin
         sout_o      <= ir_mode || tx_line;
         sir_out_n_o <= !(ir_mode && !tx_line && tx_cnt < uart_shadow_pkg::IR_PULSE);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_shadow_read;
      ce_i && rd_pop;
   endsequence
   sequence s_single_write;
      ce_i && wr_shadow && !fifo_en && !tx_load;
   endsequence

   a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack held for two cycles.");
   a_read_head: assert property (s_shadow_read |=> dat_o[7:0] == $past(rx_dout))
      else $error("shadow read did not return receive head.");
   a_upper_zero: assert property (s_shadow_read |=> dat_o[31:8] == '0)
      else $error("shadow read upper bits not zero.");
   a_alias_pop: assert property (s_shadow_read ##0 (dr && !rx_push)
                                 |=> rx_count == $past(rx_count) - 1'b1)
      else $error("aliased read did not pop receive head.");
   a_rx_overrun: assert property (ce_i && rx_push && rx_full && !rd_pop |=> oe)
      else $error("lost character did not flag overrun.");
   a_rx_keep: assert property (ce_i && fifo_en && rx_lost && !fifo_flush
                               |=> $stable(rx_count) && $stable(rx_dout))
      else $error("full receive FIFO changed on overrun.");
   a_fifo_head: assert property (s_shadow_read ##0 fifo_en ##0 (rx_count > 1)
                                 |=> dr)
      else $error("receive FIFO lost entries behind head.");
   a_tx_holding_empty_flag_clear: assert property (s_single_write ##0 tx_holding_empty_flag |=> !tx_holding_empty_flag)
      else $error("single write did not clear holding-empty.");
   a_tx_overwrite: assert property (s_single_write ##0 !tx_holding_empty_flag
                                    |=> tx_count == 1 && tx_dout == $past(dat_i[7:0]))
      else $error("pending byte not overwritten.");
   a_tx_accept: assert property (ce_i && fifo_en && wr_shadow && !tx_full && !tx_load
                                 && !fifo_flush |=> tx_count == $past(tx_count) + 1'b1)
      else $error("transmit FIFO refused a write below depth.");
   a_tx_full: assert property (ce_i && fifo_en && tx_full && wr_shadow && !tx_load
                               |=> $stable(tx_count))
      else $error("write to full transmit FIFO changed it.");
   a_ir_quiet: assert property (ce_i && !ir_mode |=> sir_out_n_o)
      else $error("infrared output pulsed in normal mode.");
endmodule // uart_shadow_rx_tx_data_port

// ===== verif/testbench.sv
// Self-checking bench for the shadow data port with a serial peer.
// Assumes the package map and one tick a clock at BAUD 1562500.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] B  = uart_shadow_pkg::SHADOW_BASE_ADDR;
   localparam logic [31:0] LS = uart_shadow_pkg::LINE_STATUS_ADDR;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o, rd;
   logic        ack_o, sin_i, sout_o, irq_o;
   logic        ce_i = 1'b1;
   logic [3:0]  sel_i = 4'hF;
   logic        sir_out_n;
   logic [7:0]  got;
   int          frames;
   int          miscompares = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n;
   always #20 clk_i = ~clk_i;
   uart_shadow_rx_tx_data_port #(.BAUD(1562500)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .sin_i(sin_i), .sir_in_i(1'b0), .sout_o(sout_o),
      .sir_out_n_o(sir_out_n), .irq_o(irq_o));
   uart_peer peer (.clk_i(clk_i), .line_i(sout_o), .line_o(sin_i),
                   .got_o(got), .cnt_o(frames));
   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // A hang counts as a mismatch.
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold until ack is seen, then idle one cycle.
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic t_reset();
      // A low clock enable must hold off the answer to a standing request.
      ce_i <= 1'b0;
      fork
         begin
            repeat (2) @(posedge clk_i);
            chk({31'h0, ack_o}, 32'h0);
            ce_i <= 1'b1;
         end
      join_none
      rdc(B + 32'h14, 32'hFFFFFFFF, 32'h0);
      rdc(32'h5000_1000, 32'hFFFFFFFF, 32'h0);
      // A write without the low byte lane must not start a frame.
      sel_i <= 4'hE;
      wb(1'b1, B, 32'h0000AB00);
      sel_i <= 4'hF;
      rdc(LS, 32'h61, 32'h60);
      $display("reset test done");
   endtask
   task automatic t_rx();
      wb(1'b1, uart_shadow_pkg::IRQ_ENABLE_ADDR, 32'h1);
      peer.send(8'hA5);
      repeat (4) @(posedge clk_i);
      rdc(LS, 32'h1, 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      rdc(B, 32'hFFFF, 32'hA5);
      wb(1'b1, uart_shadow_pkg::IRQ_CLEAR_ADDR, 32'h1);
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      peer.send(8'h11);
      peer.send(8'h22);
      repeat (4) @(posedge clk_i);
      rdc(LS, 32'h2, 32'h2);
      rdc(B + 32'h24, 32'hFF, 32'h22);
      $display("receive test done");
   endtask
   task automatic t_tx();
      n = frames;
      wb(1'b1, B + 32'h3C, 32'h1C3);
      // The first byte is already shifting, so the next one stays pending.
      wb(1'b1, B, 32'h55);
      rdc(LS, 32'h20, 32'h0);
      wb(1'b1, B, 32'h77);
      while (frames == n) @(posedge clk_i);
      chk({24'h0, got}, 32'hC3);
      while (frames < n + 2) @(posedge clk_i);
      repeat (200) @(posedge clk_i);
      chk(32'(frames - n), 32'h2);
      chk({24'h0, got}, 32'h77);
      rdc(LS, 32'h20, 32'h20);
      // Infrared mode: serial line held high, short low pulse for the start bit.
      wb(1'b1, uart_shadow_pkg::CTRL_ADDR, 32'h2);
      wb(1'b1, B, 32'h0);
      @(posedge clk_i);
      chk({30'h0, sout_o, sir_out_n}, 32'h2);
      repeat (170) @(posedge clk_i);
      $display("transmit test done");
   endtask
   task automatic t_fifo();
      wb(1'b1, uart_shadow_pkg::CTRL_ADDR, 32'h1);
      for (int i = 0; i < 17; i++)
         peer.send(8'(i + 64));
      repeat (4) @(posedge clk_i);
      rdc(LS, 32'h2, 32'h2);
      for (int i = 0; i < 16; i++)
         rdc(B + 32'(i * 4), 32'hFF, 32'(i + 64));
      n = frames;
      for (int i = 0; i < 20; i++)
         wb(1'b1, B, 32'(i + 128));
      while (frames < n + 17) @(posedge clk_i);
      repeat (400) @(posedge clk_i);
      chk(32'(frames - n), 32'h11);
      chk({24'h0, got}, 32'h90);
      $display("fifo test done");
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_rx();
      t_tx();
      t_fifo();
      close_out();
   end
endmodule // testbench

// ===== verif/uart_peer.sv
// Remote serial peer: drives the receive line and decodes the transmit line.
// Assumes the design runs one tick a clock, so one bit lasts 16 clocks.
module uart_peer (
   input  wire logic       clk_i,
   input  wire logic       line_i,
   output logic            line_o,
   output logic [7:0]      got_o,
   output int              cnt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // The line idles high between frames.
   initial line_o = 1'b1;
   initial cnt_o = 0;
   // Sends one 8N1 frame, low bit first.
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 160; i++)
      begin
         @(posedge clk_i);
         line_o <= f[i/16];
      end
      @(posedge clk_i);
   endtask
   // Samples each bit in its middle and counts whole frames.
   always
   begin
      @(negedge line_i);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (16) @(posedge clk_i);
         got_o[i] = line_i;
      end
      repeat (16) @(posedge clk_i);
      cnt_o++;
   end
endmodule // uart_peer
